// ---- abu_address_breakpoint_unit.v ----
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "abu_defines.vh"
module abu_address_breakpoint_unit (
  // Clock, reset and register bus
  input  wire        REF_CLK,
  input  wire        RST_B,
  input  wire [2:0]  REG_ADDR,
  input  wire [7:0]  REG_WDATA,
  input  wire        REG_WR,
  input  wire        REG_RD,
  output reg  [7:0]  REG_RDATA,
  // CPU core side
  input  wire [15:0] CPU_ADDR,
  input  wire        CPU_ADDR_VALID,
  input  wire        CPU_INSTR_LAST,
  input  wire        CPU_BREAK_ACK,
  input  wire        CPU_RTI_DONE,
  input  wire        CPU_IN_WAIT,
  // Break signalling to the core
  output wire        BREAK_REQ,
  output wire        BREAK_STATE,
  output wire        BREAK_FAST,
  output wire [7:0]  SWI_OPCODE,
  output wire [15:0] BREAK_VECTOR_HIGH,
  output wire [15:0] BREAK_VECTOR_LOW,
  output wire        STATUS_CLEAR_ALLOW,
  output wire        IRQ
);
  reg         match_enable;
  reg         break_active_flag;
  reg  [7:0]  breakpoint_addr_high;
  reg  [7:0]  breakpoint_addr_low;
  reg         wait_exit_flag;
  reg         clear_in_break_enable;
  reg         break_pending;
  reg         in_break;
  reg  [1:0]  irq_status;
  reg  [1:0]  irq_mask;
  wire        wr_ctrl;
  wire        wr_wait;
  wire        addr_match;
  wire        sw_break;
  wire        new_break;
  wire        wait_exit_event;
  wire [1:0]  irq_events;
  reg  [7:0]  next_rdata;
  reg         next_match_enable;
  reg         next_break_active_flag;
  reg         next_wait_exit_flag;
  reg         next_clear_in_break_enable;
  reg         next_break_pending;
  reg         next_in_break;
  reg  [1:0]  next_irq_mask;
  wire        wr_addr_high;
  wire        wr_addr_low;
  wire        wr_flag_clr;
  wire        wr_irq_stat;
  wire        wr_irq_mask;
  genvar      bit_idx;
  localparam  IRQ_BITS = 2;

  // ----------------------------------------
  // Register write decode
  // ----------------------------------------
  // Index 7 matches no decode, so a write there is dropped
  assign wr_ctrl      = REG_WR && (REG_ADDR == `ABU_OFS_CTRL);
  assign wr_addr_high = REG_WR && (REG_ADDR == `ABU_OFS_ADDR_HIGH);
  assign wr_addr_low  = REG_WR && (REG_ADDR == `ABU_OFS_ADDR_LOW);
  assign wr_wait      = REG_WR && (REG_ADDR == `ABU_OFS_WAIT_STAT);
  assign wr_flag_clr  = REG_WR && (REG_ADDR == `ABU_OFS_FLAG_CLR);
  assign wr_irq_stat  = REG_WR && (REG_ADDR == `ABU_OFS_IRQ_STAT);
  assign wr_irq_mask  = REG_WR && (REG_ADDR == `ABU_OFS_IRQ_MASK);

  // ----------------------------------------
  // Break detection
  // ----------------------------------------
  assign addr_match = match_enable && CPU_ADDR_VALID &&
                      (CPU_ADDR == {breakpoint_addr_high, breakpoint_addr_low});
  assign sw_break   = wr_ctrl && REG_WDATA[`ABU_BIT_ACTIVE];
  assign new_break  = addr_match || sw_break;
  // A break taken while the core sleeps is what wakes it
  assign wait_exit_event = CPU_BREAK_ACK && CPU_IN_WAIT;
  assign irq_events = {wait_exit_event, new_break};

  // ----------------------------------------
  // Outputs to the CPU core
  // ----------------------------------------
  // Combinational path lets a match on the last cycle start the break at once
  assign BREAK_REQ  = break_pending || new_break;
  assign BREAK_FAST = new_break && CPU_INSTR_LAST;
  assign BREAK_STATE = in_break;
  assign SWI_OPCODE = `ABU_SWI_OPCODE;
  assign BREAK_VECTOR_HIGH = `ABU_VECTOR_HIGH;
  assign BREAK_VECTOR_LOW  = `ABU_VECTOR_LOW;
  assign STATUS_CLEAR_ALLOW = !in_break || clear_in_break_enable;
  assign IRQ = |(irq_status & irq_mask);

  // ----------------------------------------
  // Next register values
  // ----------------------------------------
  // Each flag except break_pending lets its setting event win over a clear in the same cycle
  always @* begin
    next_match_enable = match_enable;
    if (wr_ctrl) begin
      next_match_enable = REG_WDATA[`ABU_BIT_MATCH_EN];
    end
  end

  always @* begin
    next_break_active_flag = break_active_flag;
    if (new_break) begin
      next_break_active_flag = 1'b1;
    end else if (wr_ctrl) begin
      next_break_active_flag = 1'b0;
    end
  end

  always @* begin
    next_wait_exit_flag = wait_exit_flag;
    if (wait_exit_event) begin
      next_wait_exit_flag = 1'b1;
    end else if (wr_wait && !REG_WDATA[`ABU_BIT_WAIT_EXIT]) begin
      next_wait_exit_flag = 1'b0;
    end
  end

  always @* begin
    next_clear_in_break_enable = clear_in_break_enable;
    if (wr_flag_clr) begin
      next_clear_in_break_enable = REG_WDATA[`ABU_BIT_CLR_EN];
    end
  end

  // The acknowledge consumes the request, including one raised in that cycle
  always @* begin
    next_break_pending = break_pending;
    if (CPU_BREAK_ACK) begin
      next_break_pending = 1'b0;
    end else if (new_break) begin
      next_break_pending = 1'b1;
    end
  end

  always @* begin
    next_in_break = in_break;
    if (CPU_BREAK_ACK) begin
      next_in_break = 1'b1;
    end else if (CPU_RTI_DONE) begin
      next_in_break = 1'b0;
    end
  end

  always @* begin
    next_irq_mask = irq_mask;
    if (wr_irq_mask) begin
      next_irq_mask = REG_WDATA[1:0];
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      match_enable <= 1'b0;
    end else begin
      match_enable <= next_match_enable;
    end
  end

  // A write with bit 6 set is itself the software break
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      break_active_flag <= 1'b0;
    end else begin
      break_active_flag <= next_break_active_flag;
    end
  end

  // ----------------------------------------
  // Breakpoint address bytes
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      breakpoint_addr_high <= `ABU_RST_BYTE;
    end else if (wr_addr_high) begin
      breakpoint_addr_high <= REG_WDATA;
    end
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      breakpoint_addr_low <= `ABU_RST_BYTE;
    end else if (wr_addr_low) begin
      breakpoint_addr_low <= REG_WDATA;
    end
  end

  // ----------------------------------------
  // Wait-exit flag and clear-in-break enable
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_exit_flag <= 1'b0;
    end else begin
      wait_exit_flag <= next_wait_exit_flag;
    end
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      clear_in_break_enable <= 1'b0;
    end else begin
      clear_in_break_enable <= next_clear_in_break_enable;
    end
  end

  // ----------------------------------------
  // Break request and break state
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      break_pending <= 1'b0;
    end else begin
      break_pending <= next_break_pending;
    end
  end

  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      in_break <= 1'b0;
    end else begin
      in_break <= next_in_break;
    end
  end

  // ----------------------------------------
  // Interrupt mask and sticky status
  // ----------------------------------------
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      irq_mask <= 2'b00;
    end else begin
      irq_mask <= next_irq_mask;
    end
  end

  // A clear during break is ignored unless enabled; an event still wins
  generate
    for (bit_idx = 0; bit_idx < IRQ_BITS; bit_idx = bit_idx + 1) begin : g_irq_bit
      always @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
          irq_status[bit_idx] <= 1'b0;
        end else if (irq_events[bit_idx]) begin
          irq_status[bit_idx] <= 1'b1;
        end else if (wr_irq_stat && REG_WDATA[bit_idx] && STATUS_CLEAR_ALLOW) begin
          irq_status[bit_idx] <= 1'b0;
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @* begin
    next_rdata = 8'h00;
    case (REG_ADDR)
      `ABU_OFS_CTRL: begin
        next_rdata = {match_enable, break_active_flag, 6'b00_0000};
      end
      `ABU_OFS_ADDR_HIGH: begin
        next_rdata = breakpoint_addr_high;
      end
      `ABU_OFS_ADDR_LOW: begin
        next_rdata = breakpoint_addr_low;
      end
      `ABU_OFS_WAIT_STAT: begin
        next_rdata = {6'b00_0000, wait_exit_flag, 1'b0};
      end
      `ABU_OFS_FLAG_CLR: begin
        next_rdata = {clear_in_break_enable, 7'b000_0000};
      end
      `ABU_OFS_IRQ_STAT: begin
        next_rdata = {6'b00_0000, irq_status};
      end
      `ABU_OFS_IRQ_MASK: begin
        next_rdata = {6'b00_0000, irq_mask};
      end
      default: begin
        next_rdata = 8'h00;
      end
    endcase
  end

  // Data stand one cycle only, so stale data never pose as a fresh read
  always @(posedge REF_CLK or negedge RST_B) begin
    if (!RST_B) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= next_rdata;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end
endmodule // abu_address_breakpoint_unit
`default_nettype wire

// ---- abu_defines.vh ----
// How it works
// - With match enable set, a 16-bit CPU address equal to breakpoint raises break.
// - Match enable is control bit 7, read/write, zero written clears, reset clears.
// - Break-active flag sets on every address match and reads back as one.
// - Writing one to break-active flag raises a break without any address match.
// - Two byte registers hold upper and lower breakpoint address bytes.
// - Reset loads both breakpoint address bytes with zero.
// - Wait-exit flag sets when a break brings the device out of wait mode.
// - Wait-exit flag is read/write, cleared by writing zero and by reset.
// - In break state, status clears allowed only when clear-in-break enable is one; the code gates only IRQ status clears, not the wait-exit flag clear.
// - On break, CPU loads software interrupt opcode and vectors from FFFC/FFFD.
// - A match on an instruction's last cycle starts the break at once.
`ifndef ABU_DEFINES_VH
`define ABU_DEFINES_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ABU_OFS_CTRL      3'h0
`define ABU_OFS_ADDR_HIGH 3'h1
`define ABU_OFS_ADDR_LOW  3'h2
`define ABU_OFS_WAIT_STAT 3'h3
`define ABU_OFS_FLAG_CLR  3'h4
`define ABU_OFS_IRQ_STAT  3'h5
`define ABU_OFS_IRQ_MASK  3'h6
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ABU_BIT_MATCH_EN  7
`define ABU_BIT_ACTIVE    6
`define ABU_BIT_WAIT_EXIT 1
`define ABU_BIT_CLR_EN    7
`define ABU_IRQ_BREAK     0
`define ABU_IRQ_WAIT      1
// ----------------------------------------
// Reset values and CPU constants
// ----------------------------------------
`define ABU_RST_BYTE      8'h00
`define ABU_VECTOR_HIGH   16'hFFFC
`define ABU_VECTOR_LOW    16'hFFFD
`define ABU_SWI_OPCODE    8'h83
`endif

// ---- abu_monitor.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "abu_defines.vh"
// ----------------------------------------
// Port checker
// ----------------------------------------
module abu_monitor (
  input wire logic        REF_CLK,
  input wire logic        RST_B,
  input wire logic        REG_WR,
  input wire logic        REG_RD,
  input wire logic        CPU_ADDR_VALID,
  input wire logic        CPU_INSTR_LAST,
  input wire logic        CPU_BREAK_ACK,
  input wire logic        CPU_RTI_DONE,
  input wire logic        CPU_IN_WAIT,
  input wire logic        BREAK_REQ,
  input wire logic        BREAK_STATE,
  input wire logic        BREAK_FAST,
  input wire logic        STATUS_CLEAR_ALLOW,
  input wire logic        IRQ,
  input wire logic [2:0]  REG_ADDR,
  input wire logic [7:0]  REG_WDATA,
  input wire logic [7:0]  REG_RDATA,
  input wire logic [7:0]  SWI_OPCODE,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [15:0] BREAK_VECTOR_HIGH,
  input wire logic [15:0] BREAK_VECTOR_LOW
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  AST_REQ_HOLD: assert property (BREAK_REQ && !CPU_BREAK_ACK |=> BREAK_REQ) else $error("request dropped");
  AST_ACK_STATE: assert property (CPU_BREAK_ACK |=> BREAK_STATE) else $error("no break state");
  AST_RTI_END: assert property (CPU_RTI_DONE && !CPU_BREAK_ACK |=> !BREAK_STATE) else $error("state stuck");
  AST_FAST: assert property (BREAK_FAST |-> BREAK_REQ && CPU_INSTR_LAST) else $error("bad fast break");
  AST_VECTOR: assert property (SWI_OPCODE == `ABU_SWI_OPCODE && BREAK_VECTOR_HIGH == `ABU_VECTOR_HIGH
    && BREAK_VECTOR_LOW == `ABU_VECTOR_LOW) else $error("bad vector");
  AST_CLR_OPEN: assert property (!BREAK_STATE |-> STATUS_CLEAR_ALLOW) else $error("clear blocked");
  AST_SW_BREAK: assert property (REG_WR && REG_ADDR == `ABU_OFS_CTRL && REG_WDATA[`ABU_BIT_ACTIVE]
    && !CPU_BREAK_ACK |=> BREAK_REQ) else $error("no soft break");
  AST_RD_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00) else $error("stray read data");
  cover property (BREAK_FAST);
  cover property (CPU_BREAK_ACK && CPU_IN_WAIT);
  cover property (IRQ);
endmodule // abu_monitor
bind abu_address_breakpoint_unit abu_monitor u_mon (.*);
`default_nettype wire

// ---- abu_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// CPU core: random instruction ends, break held until hold drops
// ----------------------------------------
module abu_cpu_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic hold,
  output logic     last,
  output logic     ack,
  output logic     rti
);
  logic busy;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      {last, ack, rti, busy} <= 4'h0;
    end else begin
      last <= 1'($urandom % 2);
      ack <= req && last && !busy && !ack;
      rti <= busy && !hold && !rti;
      busy <= ack ? 1'b1 : (rti ? 1'b0 : busy);
    end
  end
endmodule // abu_cpu_model
`default_nettype wire

// ---- address_breakpoint_unit_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
module address_breakpoint_unit_tb_top;
  logic REF_CLK = 0, RST_B = 0, REG_WR = 0, REG_RD = 0, CPU_ADDR_VALID = 0, CPU_IN_WAIT = 0, hold = 1;
  logic [2:0] REG_ADDR = 0;
  logic [7:0] REG_WDATA = 0;
  logic [15:0] CPU_ADDR = 0, bp, a;
  wire [7:0] REG_RDATA, SWI_OPCODE;
  wire [15:0] BREAK_VECTOR_HIGH, BREAK_VECTOR_LOW;
  wire CPU_INSTR_LAST, CPU_BREAK_ACK, CPU_RTI_DONE, BREAK_REQ, BREAK_STATE, BREAK_FAST, STATUS_CLEAR_ALLOW, IRQ;
  int err_total = 0, samples_checked = 0;
  abu_address_breakpoint_unit DUT (.*);
  abu_cpu_model u_cpu (.clk(REF_CLK), .rst_b(RST_B), .req(BREAK_REQ), .hold(hold),
    .last(CPU_INSTR_LAST), .ack(CPU_BREAK_ACK), .rti(CPU_RTI_DONE));
  initial forever #4 REF_CLK = ~REF_CLK;
  task chk(input [15:0] got, input [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input [2:0] ad, input [7:0] d);
    @(posedge REF_CLK) {REG_ADDR, REG_WDATA, REG_WR} <= {ad, d, 1'b1};
    @(posedge REF_CLK) REG_WR <= 0;
    #1;
  endtask
  task rd(input [2:0] ad, input [7:0] e);
    @(posedge REF_CLK) {REG_ADDR, REG_RD} <= {ad, 1'b1};
    @(posedge REF_CLK) REG_RD <= 0;
    #1 chk(REG_RDATA, e);
  endtask
  task wst(input v);
    int i;
    for (i = 0; i < 60 && BREAK_STATE !== v; i++) @(posedge REF_CLK);
    #1;
    if (BREAK_STATE !== v) begin err_total++; conclude(); end
  endtask
  task conclude;
    $display("checked %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task hit(input [15:0] ad, input e);
    @(posedge REF_CLK) {CPU_ADDR, CPU_ADDR_VALID} <= {ad, 1'b1};
    #1 chk(BREAK_REQ, e);
    chk(BREAK_FAST, e && CPU_INSTR_LAST);
    @(posedge REF_CLK) CPU_ADDR_VALID <= 0;
  endtask
  initial begin
    void'($urandom(32'h0a85));
    repeat (20) @(posedge REF_CLK);
    RST_B <= 1;
    for (int i = 0; i < 8; i++) rd(3'(i), 8'h00);
    $display("reset test done");
    bp = 16'($urandom);
    wr(1, bp[15:8]);
    wr(2, bp[7:0]);
    rd(1, bp[15:8]);
    rd(2, bp[7:0]);
    hit(bp, 0);
    CPU_IN_WAIT <= 1;
    wr(0, 8'h80);
    hit(bp, 1);
    rd(0, 8'hC0);
    wst(1);
    chk(STATUS_CLEAR_ALLOW, 0);
    rd(3, 8'h02);
    chk(IRQ, 0);
    wr(6, 8'h03);
    chk(IRQ, 1);
    wr(5, 8'h03);
    chk(IRQ, 1);
    wr(4, 8'h80);
    chk(STATUS_CLEAR_ALLOW, 1);
    wr(5, 8'h03);
    chk(IRQ, 0);
    wr(3, 8'h00);
    rd(3, 8'h00);
    wr(0, 8'h80);
    rd(0, 8'h80);
    hold <= 0;
    wst(0);
    {hold, CPU_IN_WAIT} <= 2'b10;
    $display("match test done");
    wr(0, 8'h40);
    chk(BREAK_REQ, 1);
    wst(1);
    wr(0, 8'h80);
    hold <= 0;
    wst(0);
    hold <= 1;
    for (int n = 0; n < 20; n++) begin
      a = ($urandom % 2) ? bp : bp ^ (16'h0001 << ($urandom % 16));
      hit(a, a == bp);
      if (a == bp) begin
        wst(1);
        wr(0, 8'h80);
        hold <= 0;
        wst(0);
        hold <= 1;
      end
    end
    $display("random test done");
    @(posedge REF_CLK) RST_B <= 0;
    repeat (2) @(posedge REF_CLK);
    RST_B <= 1;
    rd(0, 8'h00);
    rd(1, 8'h00);
    rd(2, 8'h00);
    rd(6, 8'h00);
    $display("second reset test done");
    conclude();
  end
endmodule // address_breakpoint_unit_tb_top
`default_nettype wire
